/* File: l2bw_cfg.svh */
// register map, field positions, reset values and rule overview of the L2 RAM arbiter
//
// Overview of operation
// - grant by programmable priority plus contention counters
// - counter increments while held off by higher priority
// - counter at threshold forces a grant
// - equal CPU and DMA priorities share bandwidth equally
// - every non-CPU request arbitrates as DMA
// - drained slave DMA port drops to priority seven
`ifndef L2BW_CFG_SVH
`define L2BW_CFG_SVH

// ==========================================================
// byte offsets on the register bus
`define L2BW_CTRL_OFS 8'h00
`define L2BW_PRIO_OFS 8'h04
`define L2BW_MAX_WAIT_OFS 8'h08
`define L2BW_STAT_OFS 8'h0C
`define L2BW_CNT_OFS 8'h10

// ==========================================================
// field positions
`define L2BW_CTRL_EN_BIT 0
`define L2BW_PRIO_CPU_LSB 0
`define L2BW_PRIO_INTERNAL_LSB 4
`define L2BW_PRIO_SLAVE_LSB 8
`define L2BW_STAT_GNT_LSB 0
`define L2BW_STAT_FORCED_BIT 4
`define L2BW_STAT_EFF_LSB 8

// ==========================================================
// reset values and fixed levels
`define L2BW_CTRL_EN_RST 1'b1
`define L2BW_CPU_PRI_RST 3'h1
`define L2BW_INTERNAL_PRI_RST 3'h0
`define L2BW_SLAVE_PRI_RST 3'h0
`define L2BW_MAX_WAIT_RST 8'h10
`define L2BW_DRAINED_PRI 3'h7

`endif

/* File: l2bw_pkg.sv */
// types shared by the L2 RAM arbiter files
package l2bw_pkg;
  typedef logic [2:0] prio_t;
  typedef enum logic [1:0] {
    REQ_CPU = 2'b00,
    REQ_INTERNAL_DMA = 2'b01,
    REQ_SLAVE_DMA_PORT = 2'b10
  } req_id_t;
endpackage

/* File: contention_counter.sv */
// per-request contention cycle counter with threshold compare
`timescale 1ns/1ns
`default_nettype none
module contention_counter #(
  parameter int CNT_W = 8
) (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic req_in, // request pending
  input wire logic gnt_in, // request granted this cycle
  input wire logic blocked_in, // held off by a higher priority
  input wire logic [CNT_W-1:0] thr_in, // max wait threshold
  output logic [CNT_W-1:0] count_out, // current count
  output logic at_max_out // threshold reached
);
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  wire clear = gnt_in | ~req_in;
  wire bump = blocked_in & ~at_max_out;

  // saturating at the threshold keeps the force flag steady until served
  assign at_max_out = req_in & (count_q >= thr_in);
  assign count_d = clear ? '0 : (bump ? count_q + 1'b1 : count_q);
  assign count_out = count_q;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) count_q <= '0;
    else count_q <= count_d;
  end

  AST_CNT_STEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    blocked_in && !at_max_out && !gnt_in |=> count_q == $past(count_q) + 1'b1)
    else $error("contention count did not step while blocked");
endmodule
`default_nettype wire

/* File: l2_ram_bandwidth_arbiter.sv */
// bandwidth arbiter sharing L2 RAM between CPU and DMA requesters
`timescale 1ns/1ns
`default_nettype none
`include "l2bw_cfg.svh"
module l2_ram_bandwidth_arbiter
  import l2bw_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic CLK_IN, // 125 MHz system clock
  input wire logic RST_N_IN, // synchronous reset, active low
  input wire logic CYC_IN, // wishbone cycle
  input wire logic STB_IN, // wishbone strobe
  input wire logic WE_IN, // wishbone write enable
  input wire logic [7:0] ADR_IN, // wishbone byte address
  input wire logic [3:0] SEL_IN, // wishbone byte enables
  input wire logic [31:0] DAT_IN, // wishbone write data
  output logic [31:0] DAT_OUT, // wishbone read data
  output logic ACK_OUT, // wishbone acknowledge
  input wire logic CPU_REQ_IN, // CPU request pending
  input wire logic INTERNAL_DMA_REQ_IN, // internal DMA request pending
  input wire logic SLAVE_DMA_PORT_REQ_IN, // system master request pending
  input wire logic SLAVE_DMA_PORT_DRAINED_IN, // port has sent all commands
  output logic CPU_GNT_OUT, // CPU granted this cycle
  output logic INTERNAL_DMA_GNT_OUT, // internal DMA granted this cycle
  output logic SLAVE_DMA_PORT_GNT_OUT // system master granted this cycle
);
  // ==========================================================
  // parameter check
  if (CNT_W < 1 || CNT_W > 8) begin : g_bad_w
    $error("CNT_W must lie in 1..8");
  end

  // ==========================================================
  // registers
  logic ctrl_en_q;
  prio_t cpu_pri_q;
  prio_t internal_dma_pri_q;
  prio_t slave_port_pri_q;
  logic [CNT_W-1:0] max_wait_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [1:0] last_q;
  logic forced_q;

  wire [7:0] adr_w = {ADR_IN[7:2], 2'b00};
  wire bus_req = CYC_IN & STB_IN;
  // the write strobe waits for ack so every access lands exactly once
  wire wr_fire = bus_req & WE_IN & ack_q;
  wire sel_ctrl = adr_w == `L2BW_CTRL_OFS;
  wire sel_prio = adr_w == `L2BW_PRIO_OFS;
  wire sel_mw = adr_w == `L2BW_MAX_WAIT_OFS;
  wire sel_stat = adr_w == `L2BW_STAT_OFS;
  wire sel_cnt = adr_w == `L2BW_CNT_OFS;

  // ==========================================================
  // arbitration
  prio_t eff [3];
  // enable low masks every request, so the counters fall back to zero too
  wire [2:0] req = {SLAVE_DMA_PORT_REQ_IN, INTERNAL_DMA_REQ_IN, CPU_REQ_IN} & {3{ctrl_en_q}};
  logic [2:0] higher;
  logic [2:0] at_max;
  logic [2:0] gnt;
  logic [CNT_W-1:0] cnt [3];
  logic [23:0] cnt_rd;

  assign eff[0] = cpu_pri_q;
  assign eff[1] = internal_dma_pri_q;
  // drained port competes at the fixed level seven instead of its programmed level
  assign eff[2] = SLAVE_DMA_PORT_DRAINED_IN ? `L2BW_DRAINED_PRI : slave_port_pri_q;

  // rotating pick keeps equal levels fair instead of always favouring the CPU
  function automatic logic [2:0] pick(input logic [2:0] m, input logic [1:0] last);
    logic [2:0] r;
    int idx;
    r = 3'h0;
    for (int k = 3; k >= 1; k--) begin
      idx = (int'(last) + k) % 3;
      if (m[idx]) r = 3'(1 << idx);
    end
    return r;
  endfunction

  // a starved requester pre-empts priority so nobody waits forever
  wire [2:0] starve = req & at_max;
  wire forced = |starve;
  wire [2:0] cand = forced ? starve : (req & ~higher);
  assign gnt = pick(cand, last_q);

  // one counter per requester, saturating at the threshold
  for (genvar i = 0; i < 3; i++) begin : g_req
    assign higher[i] = (req[0] && eff[0] < eff[i]) || (req[1] && eff[1] < eff[i])
                       || (req[2] && eff[2] < eff[i]);
    contention_counter #(.CNT_W(CNT_W)) u_cnt (
      .clk_in(CLK_IN),
      .rst_n_in(RST_N_IN),
      .req_in(req[i]),
      .gnt_in(gnt[i]),
      .blocked_in(req[i] & ~gnt[i] & higher[i]),
      .thr_in(max_wait_q),
      .count_out(cnt[i]),
      .at_max_out(at_max[i])
    );
    assign cnt_rd[i*8 +: 8] = 8'(cnt[i]);
  end

  assign CPU_GNT_OUT = gnt[0];
  assign INTERNAL_DMA_GNT_OUT = gnt[1];
  assign SLAVE_DMA_PORT_GNT_OUT = gnt[2];

  // status shows only the latest winner; earlier grants are not kept
  wire [1:0] gnt_idx = gnt[2] ? 2'h2 : (gnt[1] ? 2'h1 : 2'h0);

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      last_q <= REQ_SLAVE_DMA_PORT;
      forced_q <= 1'b0;
    end else if (|gnt) begin
      last_q <= gnt_idx;
      forced_q <= forced;
    end
  end

  // ==========================================================
  // register bus slave
  // reads are latched at the request edge; writes land on the acknowledged edge
  wire [31:0] ctrl_word = {31'h0, ctrl_en_q};
  wire [31:0] prio_word = {21'h0, slave_port_pri_q, 1'b0, internal_dma_pri_q, 1'b0, cpu_pri_q};
  wire [31:0] mw_word = {24'h0, 8'(max_wait_q)};
  wire [31:0] stat_word = {21'h0, eff[2], 3'h0, forced_q, 2'h0, last_q};
  wire [31:0] cnt_word = {8'h0, cnt_rd};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_word
    : sel_prio ? prio_word
    : sel_mw ? mw_word
    : sel_stat ? stat_word
    : sel_cnt ? cnt_word
    : 32'h0;

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= bus_req & ~ack_q;
      if (bus_req & ~ack_q) rdat_q <= rd_mux;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ctrl_en_q <= `L2BW_CTRL_EN_RST;
      cpu_pri_q <= `L2BW_CPU_PRI_RST;
      internal_dma_pri_q <= `L2BW_INTERNAL_PRI_RST;
      slave_port_pri_q <= `L2BW_SLAVE_PRI_RST;
      max_wait_q <= CNT_W'(`L2BW_MAX_WAIT_RST);
    end else if (wr_fire) begin
      if (sel_ctrl && SEL_IN[0]) ctrl_en_q <= DAT_IN[`L2BW_CTRL_EN_BIT];
      if (sel_prio && SEL_IN[0]) cpu_pri_q <= DAT_IN[`L2BW_PRIO_CPU_LSB +: 3];
      if (sel_prio && SEL_IN[0]) internal_dma_pri_q <= DAT_IN[`L2BW_PRIO_INTERNAL_LSB +: 3];
      if (sel_prio && SEL_IN[1]) slave_port_pri_q <= DAT_IN[`L2BW_PRIO_SLAVE_LSB +: 3];
      if (sel_mw && SEL_IN[0]) max_wait_q <= DAT_IN[CNT_W-1:0];
    end
  end

  assign ACK_OUT = ack_q;
  assign DAT_OUT = rdat_q;

  // ==========================================================
  // checks
  AST_PRIO_ORDER: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !forced |-> (gnt & higher) == 3'h0)
    else $error("lower priority granted without forced grant");

  AST_FORCED_GNT: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    forced |-> (gnt & starve) != 3'h0)
    else $error("starved request not granted");

  AST_EQUAL_SHARE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (!forced && gnt[0] && req[1] && !higher[1]) ##1
    (!forced && req[0] && req[1] && !higher[0] && !higher[1]) |-> !gnt[0])
    else $error("CPU granted twice over an equal DMA request");

  AST_GNT_LEGAL: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    $onehot0(gnt) && (gnt & ~req) == 3'h0 && (|req == |gnt))
    else $error("grant not one-hot or not to a requester");

  AST_DRAINED_LOW: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    SLAVE_DMA_PORT_DRAINED_IN && req[0] && cpu_pri_q != 3'h7 && !forced
    |-> !SLAVE_DMA_PORT_GNT_OUT)
    else $error("drained slave port beat the CPU");

  AST_MAX_WAIT_THRESHOLD_WR: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    wr_fire && sel_mw && SEL_IN[0] |=> max_wait_q == $past(DAT_IN[CNT_W-1:0]))
    else $error("max wait threshold write lost");

  AST_DISABLED_IDLE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    !ctrl_en_q
    |-> gnt == 3'h0)
    else $error("grant given while arbitration disabled");

  AST_FORCED_STATUS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    (|gnt)
    |=> forced_q == $past(forced))
    else $error("forced grant status not recorded");

  AST_GNT_CLEARS: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    gnt[0]
    |=> cnt[0] == '0)
    else $error("CPU contention count kept after its grant");

  AST_ACK_PULSE: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    ack_q
    |=> !ack_q)
    else $error("acknowledge held longer than one cycle");

  AST_PRIO_WR: assert property (@(posedge CLK_IN) disable iff (!RST_N_IN)
    wr_fire && sel_prio && SEL_IN[0]
    |=> cpu_pri_q == $past(DAT_IN[`L2BW_PRIO_CPU_LSB +: 3]))
    else $error("CPU priority write lost");
endmodule
`default_nettype wire

/* File: req_model.sv */
// requestor model for the CPU and DMA sides
`timescale 1ns/1ns
`default_nettype none
module req_model (
  input wire logic clk_in, // system clock
  input wire logic rst_n_in, // sync reset, active low
  input wire logic want_in, // keep asking
  input wire logic gnt_in, // grant seen
  output logic req_out // request level
);
  // a request is never withdrawn before its grant
  always_ff @(posedge clk_in) begin
    req_out <= rst_n_in & (want_in | (req_out & ~gnt_in));
  end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the L2 RAM arbiter
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, drn = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, e, d;
  logic ack, cg, ig, sg, cr, ir, sr;
  logic [2:0] want = 3'h0, m, msk;
  int failures = 0, total_checks = 0, n, nc, ni;
  logic [31:0] expq[$];
`define CHK(s, x, g) begin total_checks++; if ((g) !== (x)) begin failures++; \
  $display("CHECK FAILED %s exp %0h got %0h", s, x, g); end end
  l2_ram_bandwidth_arbiter dut (.CLK_IN(clk), .RST_N_IN(rst_n), .CYC_IN(cyc),
    .STB_IN(stb), .WE_IN(we), .ADR_IN(adr), .SEL_IN(sel), .DAT_IN(dat), .DAT_OUT(rdat),
    .ACK_OUT(ack), .CPU_REQ_IN(cr), .INTERNAL_DMA_REQ_IN(ir), .SLAVE_DMA_PORT_REQ_IN(sr),
    .SLAVE_DMA_PORT_DRAINED_IN(drn), .CPU_GNT_OUT(cg), .INTERNAL_DMA_GNT_OUT(ig),
    .SLAVE_DMA_PORT_GNT_OUT(sg));
  req_model m0 (.clk_in(clk), .rst_n_in(rst_n), .want_in(want[0]), .gnt_in(cg), .req_out(cr));
  req_model m1 (.clk_in(clk), .rst_n_in(rst_n), .want_in(want[1]), .gnt_in(ig), .req_out(ir));
  req_model m2 (.clk_in(clk), .rst_n_in(rst_n), .want_in(want[2]), .gnt_in(sg), .req_out(sr));
  initial begin
    forever #4 clk = ~clk;
  end
  // ==========
  // bus tasks
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= v;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      failures++;
      close_out();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back(x);
    wb(1'b0, a, 32'h0);
  endtask
  task automatic close_out;
    if (failures == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // read data is compared at its ack edge
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e = (expq.size() > 0) ? expq.pop_front() : 32'hDEAD;
      `CHK("read_data", e, rdat)
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    close_out();
  end
  // ==========
  // scenarios
  initial begin
    void'($urandom(9973));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h1);
    rd(8'h08, 32'h10);
    rd(8'h0C, 32'h2);
    rd(8'h10, 32'h0);
    wb(1'b1, 8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h0);
    wb(1'b1, 8'h04, 32'h312);
    rd(8'h04, 32'h312);
    wb(1'b1, 8'h08, 32'h4);
    want <= 3'b011;
    @(posedge clk);
    #1;
    `CHK("urgent_first", 1'b1, ig)
    n = 0;
    while (cg !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("forced_wait", 4, n)
    @(posedge clk);
    want <= 3'b000;
    repeat (4) @(posedge clk);
    wb(1'b1, 8'h04, 32'h111);
    want <= 3'b011;
    @(posedge clk);
    nc = 0;
    ni = 0;
    repeat (4) begin
      @(posedge clk);
      #1;
      nc += int'(cg === 1'b1);
      ni += int'(ig === 1'b1);
    end
    `CHK("fair_cpu", 2, nc)
    `CHK("fair_dma", 2, ni)
    @(posedge clk);
    want <= 3'b000;
    repeat (4) @(posedge clk);
    wb(1'b1, 8'h04, 32'h072);
    want <= 3'b101;
    @(posedge clk);
    @(posedge clk);
    #1;
    `CHK("port_is_dma", 1'b1, sg)
    @(posedge clk);
    drn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("drained_low", 2'b01, {sg, cg})
    @(posedge clk);
    want <= 3'b000;
    drn <= 1'b0;
    repeat (4) @(posedge clk);
    wb(1'b1, 8'h00, 32'h0);
    want <= 3'b111;
    repeat (3) @(posedge clk);
    #1;
    `CHK("disabled", 3'b000, {sg, ig, cg})
    @(posedge clk);
    wb(1'b1, 8'h00, 32'h1);
    want <= 3'b000;
    repeat (6) @(posedge clk);
    wb(1'b1, 8'h08, 32'hFF);
    // random level mixes, lowest number must win
    repeat (8) begin
      d = $urandom & 32'h777;
      wb(1'b1, 8'h04, d);
      want <= 3'b111;
      @(posedge clk);
      @(posedge clk);
      #1;
      m = d[2:0] < d[6:4] ? d[2:0] : d[6:4];
      m = m < d[10:8] ? m : d[10:8];
      msk = {d[10:8] == m, d[6:4] == m, d[2:0] == m};
      `CHK("one_grant", 1'b1, $onehot({sg, ig, cg}))
      `CHK("winner", 3'b000, {sg, ig, cg} & ~msk)
      @(posedge clk);
      want <= 3'b000;
      repeat (5) @(posedge clk);
    end
    close_out();
  end
endmodule
`default_nettype wire
